// >>> design/rsa_pkg.sv
package rsa_pkg;

  // ----------------------------------------------------------------------
  // Function and exception codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [15:0] DIAG_ECHO_SUB = 16'h0000;

  // ----------------------------------------------------------------------
  // Addressing and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] STATION_MAX = 8'hF7;
  localparam logic [15:0] MAX_READ_CNT = 16'h007D;
  // A register index N names holding register HREG_BASE + N.
  localparam int unsigned HREG_BASE = 40001;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int BUF_DEPTH = 8;
  localparam logic [7:0] QUERY_LEN = 8'h08;
  localparam logic [7:0] QUERY_BODY = 8'h06;
  localparam logic [7:0] FRAME_MIN = 8'h04;
  localparam logic [7:0] ECHO_LEN = 8'h06;
  localparam logic [7:0] EXC_LEN = 8'h03;
  localparam logic [7:0] RD_HDR_LEN = 8'h03;
  localparam logic [7:0] LEN_MAX = 8'hFF;

  // ----------------------------------------------------------------------
  // Checksum
  // ----------------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BCAST_WAIT_NS = 200000;
  localparam int unsigned RSP_TIMEOUT_NS = 1000000;
  localparam logic [15:0] BCAST_WAIT_CYC_DEF =
    16'((BCAST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RSP_TIMEOUT_CYC_DEF =
    16'((RSP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// >>> design/rsa_link_if.sv
interface rsa_link_if;
  logic [7:0] m2s_data;
  logic m2s_valid;
  logic m2s_end;
  logic [7:0] s2m_data;
  logic s2m_valid;
  logic s2m_end;

  modport dev (
    input m2s_data, m2s_valid, m2s_end,
    output s2m_data, s2m_valid, s2m_end
  );

  modport mst (
    output m2s_data, m2s_valid, m2s_end,
    input s2m_data, s2m_valid, s2m_end
  );
endinterface

// >>> design/rsa_dev_end.sv
// Contract
// - Read query: address, 03, start, count, CRC.
// - Broadcast read is invalid, never answered.
// - Start field N means register 40001+N.
// - Read count is at most 125.
// - Read reply: address, function, byte count 2n.
// - Read words high byte first, ascending addresses.
// - Reads reach all holding register areas.
// - Writes reach only variables and parameters.
// - Write query: address, 06, register, data, CRC.
// - Write register field N means 40001+N.
// - Preset data is exactly two bytes.
// - Addressed write is echoed unchanged.
// - Broadcast write gets no reply.
// - Master waits after broadcast before next query.
// - Diagnostic subfunction 0000 echoes the query.
// - Answer only own station 1 to 247.
// - Errors return function code plus 80.
// - Receiver recomputes CRC, mismatch is error.
module rsa_dev_end
  import rsa_pkg::*;
(
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  rsa_link_if.dev link, // Byte link to the master.
  input wire logic [7:0] station_addr, // Own station address.
  output logic rd_req, // Register read request pulse.
  output logic [15:0] rd_index, // Register index to read.
  input wire logic rd_ack, // Read answer strobe.
  input wire logic [15:0] rd_data, // Read data with rd_ack.
  input wire logic rd_err, // Read refused with rd_ack.
  output logic wr_req, // Register write request pulse.
  output logic [15:0] wr_index, // Register index to write.
  output logic [15:0] wr_data, // Write data.
  input wire logic wr_ack, // Write answer strobe.
  input wire logic wr_err, // Write refused with wr_ack.
  output logic frame_drop // Pulse when a frame is discarded.
);

  typedef enum logic [2:0] {
    ST_RX = 3'b000,
    ST_CHECK = 3'b001,
    ST_WRITE = 3'b010,
    ST_FETCH = 3'b011,
    ST_TX = 3'b100
  } rsa_dev_state_t;

  typedef enum logic [1:0] {
    TX_ECHO = 2'b00,
    TX_READ = 2'b01,
    TX_EXC = 2'b10
  } rsa_tx_kind_t;

  rsa_dev_state_t state_q, state_d;
  rsa_tx_kind_t kind_q, kind_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [7:0] buf_d [BUF_DEPTH];
  logic [7:0] len_q, len_d;
  logic [15:0] crc_q, crc_d;
  logic [15:0] txcrc_q, txcrc_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] exc_q, exc_d;
  logic [15:0] word_q, word_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_valid_q, tx_valid_d;
  logic tx_end_q, tx_end_d;
  logic rd_req_q, rd_req_d;
  logic [15:0] rd_index_q, rd_index_d;
  logic wr_req_q, wr_req_d;
  logic [15:0] wr_index_q, wr_index_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic drop_q, drop_d;

  logic [15:0] q_addr;
  logic [15:0] q_val;
  logic crc_ok;
  logic mine;
  logic bcast;
  logic [7:0] body;
  logic [7:0] tx_byte;

  // Fields of the stored query, all sent high byte first.
  assign q_addr = {buf_q[2], buf_q[3]};
  assign q_val = {buf_q[4], buf_q[5]};
  // Running CRC over the whole frame, check field included, leaves zero.
  assign crc_ok = (crc_q == 16'h0000) && (len_q >= FRAME_MIN);
  assign mine = (buf_q[0] == station_addr) && (station_addr != BCAST_ADDR)
    && (station_addr <= STATION_MAX);
  assign bcast = (buf_q[0] == BCAST_ADDR);

  // ----------------------------------------------------------------------
  // Reply byte selection
  // ----------------------------------------------------------------------
  always_comb begin
    body = ECHO_LEN;
    if (kind_q == TX_EXC) begin
      body = EXC_LEN;
    end else if (kind_q == TX_READ) begin
      body = RD_HDR_LEN + {q_val[6:0], 1'b0};
    end
    tx_byte = txcrc_q[15:8];
    if (idx_q < body) begin
      case (kind_q)
        TX_ECHO: tx_byte = buf_q[idx_q[2:0]];
        TX_EXC: begin
          if (idx_q == 8'h00) begin
            tx_byte = buf_q[0];
          end else if (idx_q == 8'h01) begin
            tx_byte = buf_q[1] | EXC_FLAG;
          end else begin
            tx_byte = exc_q;
          end
        end
        default: begin
          if (idx_q == 8'h00) begin
            tx_byte = buf_q[0];
          end else if (idx_q == 8'h01) begin
            tx_byte = buf_q[1];
          end else if (idx_q == 8'h02) begin
            tx_byte = {q_val[6:0], 1'b0};
          end else begin
            tx_byte = idx_q[0] ? word_q[15:8] : word_q[7:0];
          end
        end
      endcase
    end else if (idx_q == body) begin
      tx_byte = txcrc_q[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Frame handler
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    buf_d = buf_q;
    len_d = len_q;
    crc_d = crc_q;
    txcrc_d = txcrc_q;
    idx_d = idx_q;
    exc_d = exc_q;
    word_d = word_q;
    tx_data_d = tx_data_q;
    tx_valid_d = 1'b0;
    tx_end_d = 1'b0;
    rd_req_d = 1'b0;
    rd_index_d = rd_index_q;
    wr_req_d = 1'b0;
    wr_index_d = wr_index_q;
    wr_data_d = wr_data_q;
    drop_d = 1'b0;
    case (state_q)
      ST_RX: begin
        if (link.m2s_valid) begin
          if (len_q < QUERY_LEN) begin
            buf_d[len_q[2:0]] = link.m2s_data;
          end
          if (len_q != LEN_MAX) begin
            len_d = len_q + 8'h01;
          end
          crc_d = crc_byte(crc_q, link.m2s_data);
          if (link.m2s_end) begin
            state_d = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        state_d = ST_RX;
        len_d = 8'h00;
        crc_d = CRC_INIT;
        txcrc_d = CRC_INIT;
        idx_d = 8'h00;
        if (!crc_ok || !(mine || bcast)) begin
          drop_d = 1'b1;
        end else if (bcast && buf_q[1] != FN_WRITE) begin
          drop_d = 1'b1;
        end else if (buf_q[1] == FN_WRITE) begin
          if (len_q != QUERY_LEN) begin
            drop_d = bcast;
            kind_d = TX_EXC;
            exc_d = EXC_ILL_VALUE;
            state_d = bcast ? ST_RX : ST_TX;
          end else begin
            wr_req_d = 1'b1;
            wr_index_d = q_addr;
            wr_data_d = q_val;
            state_d = ST_WRITE;
          end
        end else if (len_q != QUERY_LEN) begin
          kind_d = TX_EXC;
          exc_d = (buf_q[1] == FN_READ || buf_q[1] == FN_DIAG) ? EXC_ILL_VALUE
            : EXC_ILL_FUNC;
          state_d = ST_TX;
        end else if (buf_q[1] == FN_READ) begin
          if (q_val == 16'h0000 || q_val > MAX_READ_CNT) begin
            kind_d = TX_EXC;
            exc_d = EXC_ILL_VALUE;
            state_d = ST_TX;
          end else begin
            kind_d = TX_READ;
            rd_req_d = 1'b1;
            rd_index_d = q_addr;
            state_d = ST_FETCH;
          end
        end else if (buf_q[1] == FN_DIAG) begin
          kind_d = (q_addr == DIAG_ECHO_SUB) ? TX_ECHO : TX_EXC;
          exc_d = EXC_ILL_FUNC;
          state_d = ST_TX;
        end else begin
          kind_d = TX_EXC;
          exc_d = EXC_ILL_FUNC;
          state_d = ST_TX;
        end
      end
      ST_WRITE: begin
        if (wr_ack) begin
          // The register map refuses writes to monitor and history areas.
          kind_d = wr_err ? TX_EXC : TX_ECHO;
          exc_d = EXC_ILL_ADDR;
          state_d = bcast ? ST_RX : ST_TX;
        end
      end
      ST_FETCH: begin
        if (rd_ack) begin
          // Only the first word can still turn into an exception; once the
          // header is out, a refused word is sent as zero.
          if (rd_err && idx_q == 8'h00) begin
            kind_d = TX_EXC;
            exc_d = EXC_ILL_ADDR;
          end
          word_d = rd_err ? 16'h0000 : rd_data;
          state_d = ST_TX;
        end
      end
      ST_TX: begin
        tx_valid_d = 1'b1;
        tx_data_d = tx_byte;
        idx_d = idx_q + 8'h01;
        if (idx_q < body) begin
          txcrc_d = crc_byte(txcrc_q, tx_byte);
        end
        if (idx_q == body + 8'h01) begin
          tx_end_d = 1'b1;
          state_d = ST_RX;
        end else if (kind_q == TX_READ && idx_q > RD_HDR_LEN && !idx_q[0]
                     && (idx_q + 8'h01) < body) begin
          rd_req_d = 1'b1;
          rd_index_d = rd_index_q + 16'h0001;
          state_d = ST_FETCH;
        end
      end
      default: state_d = ST_RX;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RX;
      kind_q <= TX_ECHO;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_q[i] <= 8'h00;
      end
      len_q <= 8'h00;
      crc_q <= CRC_INIT;
      txcrc_q <= CRC_INIT;
      idx_q <= 8'h00;
      exc_q <= 8'h00;
      word_q <= 16'h0000;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_end_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_index_q <= 16'h0000;
      wr_req_q <= 1'b0;
      wr_index_q <= 16'h0000;
      wr_data_q <= 16'h0000;
      drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      buf_q <= buf_d;
      len_q <= len_d;
      crc_q <= crc_d;
      txcrc_q <= txcrc_d;
      idx_q <= idx_d;
      exc_q <= exc_d;
      word_q <= word_d;
      tx_data_q <= tx_data_d;
      tx_valid_q <= tx_valid_d;
      tx_end_q <= tx_end_d;
      rd_req_q <= rd_req_d;
      rd_index_q <= rd_index_d;
      wr_req_q <= wr_req_d;
      wr_index_q <= wr_index_d;
      wr_data_q <= wr_data_d;
      drop_q <= drop_d;
    end
  end

  assign link.s2m_data = tx_data_q;
  assign link.s2m_valid = tx_valid_q;
  assign link.s2m_end = tx_end_q;
  assign rd_req = rd_req_q;
  assign rd_index = rd_index_q;
  assign wr_req = wr_req_q;
  assign wr_index = wr_index_q;
  assign wr_data = wr_data_q;
  assign frame_drop = drop_q;

endmodule

// >>> design/rsa_mst_end.sv
module rsa_mst_end
  import rsa_pkg::*;
#(
  parameter logic [15:0] BCAST_WAIT_CYC = BCAST_WAIT_CYC_DEF,
  parameter logic [15:0] RSP_TIMEOUT_CYC = RSP_TIMEOUT_CYC_DEF
) (
  input wire logic ref_clk, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  rsa_link_if.mst link, // Byte link to the slave.
  input wire logic cmd_valid, // Command request.
  output logic cmd_ready, // Ready for a command.
  input wire logic [7:0] cmd_slave, // Slave address, 0 broadcasts.
  input wire logic [7:0] cmd_func, // Function code.
  input wire logic [15:0] cmd_word_a, // Address or subfunction.
  input wire logic [15:0] cmd_word_b, // Count or data.
  output logic rsp_valid, // Reply byte strobe.
  output logic [7:0] rsp_byte, // Reply byte.
  output logic rsp_done, // Command finished pulse.
  output logic rsp_crc_ok, // Reply CRC was good.
  output logic rsp_exc, // Reply carried the error flag.
  output logic rsp_timeout, // No reply in time.
  output logic rsp_refused // Command was not legal to send.
);

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_SEND = 2'b01,
    M_WAIT = 2'b10,
    M_GAP = 2'b11
  } rsa_mst_state_t;

  rsa_mst_state_t state_q, state_d;
  logic [7:0] frm_q [QUERY_BODY];
  logic [7:0] frm_d [QUERY_BODY];
  logic [7:0] idx_q, idx_d;
  logic [15:0] crc_q, crc_d;
  logic [15:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic tx_valid_q, tx_valid_d;
  logic tx_end_q, tx_end_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic rv_q, rv_d;
  logic [7:0] rb_q, rb_d;
  logic done_q, done_d;
  logic ok_q, ok_d;
  logic exc_q, exc_d;
  logic to_q, to_d;
  logic ref_q, ref_d;
  logic [7:0] tx_byte;
  logic [15:0] rx_crc;

  always_comb begin
    tx_byte = crc_q[15:8];
    if (idx_q < QUERY_BODY) begin
      tx_byte = frm_q[idx_q[2:0]];
    end else if (idx_q == QUERY_BODY) begin
      tx_byte = crc_q[7:0];
    end
    rx_crc = crc_byte(crc_q, link.s2m_data);
  end

  always_comb begin
    state_d = state_q;
    frm_d = frm_q;
    idx_d = idx_q;
    crc_d = crc_q;
    cnt_d = cnt_q;
    ready_d = ready_q;
    tx_valid_d = 1'b0;
    tx_end_d = 1'b0;
    tx_data_d = tx_data_q;
    rv_d = 1'b0;
    rb_d = rb_q;
    done_d = 1'b0;
    ok_d = ok_q;
    exc_d = exc_q;
    to_d = to_q;
    ref_d = ref_q;
    case (state_q)
      M_IDLE: begin
        ready_d = 1'b1;
        if (cmd_valid && ready_q) begin
          ready_d = 1'b0;
          ok_d = 1'b0;
          exc_d = 1'b0;
          to_d = 1'b0;
          ref_d = 1'b0;
          idx_d = 8'h00;
          crc_d = CRC_INIT;
          frm_d[0] = cmd_slave;
          frm_d[1] = cmd_func;
          frm_d[2] = cmd_word_a[15:8];
          frm_d[3] = cmd_word_a[7:0];
          frm_d[4] = cmd_word_b[15:8];
          frm_d[5] = cmd_word_b[7:0];
          state_d = M_SEND;
          if (cmd_slave > STATION_MAX
              || (cmd_slave == BCAST_ADDR && cmd_func != FN_WRITE)) begin
            ref_d = 1'b1;
          end else if (cmd_func == FN_READ
                       && (cmd_word_b == 16'h0000 || cmd_word_b > MAX_READ_CNT)) begin
            ref_d = 1'b1;
          end
          if (ref_d) begin
            done_d = 1'b1;
            ready_d = 1'b1;
            state_d = M_IDLE;
          end
        end
      end
      M_SEND: begin
        tx_valid_d = 1'b1;
        tx_data_d = tx_byte;
        idx_d = idx_q + 8'h01;
        if (idx_q < QUERY_BODY) begin
          crc_d = crc_byte(crc_q, tx_byte);
        end
        if (idx_q == QUERY_LEN - 8'h01) begin
          tx_end_d = 1'b1;
          cnt_d = 16'h0000;
          idx_d = 8'h00;
          crc_d = CRC_INIT;
          state_d = (frm_q[0] == BCAST_ADDR) ? M_GAP : M_WAIT;
        end
      end
      M_WAIT: begin
        cnt_d = cnt_q + 16'h0001;
        if (link.s2m_valid) begin
          rv_d = 1'b1;
          rb_d = link.s2m_data;
          crc_d = rx_crc;
          if (idx_q != LEN_MAX) begin
            idx_d = idx_q + 8'h01;
          end
          if (idx_q == 8'h01) begin
            exc_d = link.s2m_data[7];
          end
          if (link.s2m_end) begin
            ok_d = (rx_crc == 16'h0000);
            done_d = 1'b1;
            state_d = M_IDLE;
          end
        end else if (cnt_q >= RSP_TIMEOUT_CYC) begin
          to_d = 1'b1;
          done_d = 1'b1;
          state_d = M_IDLE;
        end
      end
      M_GAP: begin
        // No reply will come, so the slave is given its processing time.
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == BCAST_WAIT_CYC) begin
          done_d = 1'b1;
          state_d = M_IDLE;
        end
      end
      default: state_d = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= M_IDLE;
      for (int i = 0; i < QUERY_BODY; i++) begin
        frm_q[i] <= 8'h00;
      end
      idx_q <= 8'h00;
      crc_q <= CRC_INIT;
      cnt_q <= 16'h0000;
      ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_end_q <= 1'b0;
      tx_data_q <= 8'h00;
      rv_q <= 1'b0;
      rb_q <= 8'h00;
      done_q <= 1'b0;
      ok_q <= 1'b0;
      exc_q <= 1'b0;
      to_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      state_q <= state_d;
      frm_q <= frm_d;
      idx_q <= idx_d;
      crc_q <= crc_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
      tx_valid_q <= tx_valid_d;
      tx_end_q <= tx_end_d;
      tx_data_q <= tx_data_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      done_q <= done_d;
      ok_q <= ok_d;
      exc_q <= exc_d;
      to_q <= to_d;
      ref_q <= ref_d;
    end
  end

  assign link.m2s_data = tx_data_q;
  assign link.m2s_valid = tx_valid_q;
  assign link.m2s_end = tx_end_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_byte = rb_q;
  assign rsp_done = done_q;
  assign rsp_crc_ok = ok_q;
  assign rsp_exc = exc_q;
  assign rsp_timeout = to_q;
  assign rsp_refused = ref_q;

endmodule

// >>> sim/rsa_link_sva.sv
module rsa_link_sva
  import rsa_pkg::*;
(
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [7:0] m2s_data, // Query byte.
  input wire logic m2s_valid, // Query strobe.
  input wire logic m2s_end, // Query last byte.
  input wire logic [7:0] s2m_data, // Reply byte.
  input wire logic s2m_valid, // Reply strobe.
  input wire logic s2m_end // Reply last byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pos_q, pos_d;
  logic [7:0] spos_q, spos_d, qa_q, qa_d, qf_q, qf_d, qn_q, qn_d;

  // ----
  // Query and reply tracking
  // ----
  // Read replies pause between words, so the reply position is counted.
  always_comb begin
    pos_d = m2s_valid ? pos_q + 4'h1 : 4'h0;
    spos_d = s2m_valid ? (s2m_end ? 8'h00 : spos_q + 8'h01) : spos_q;
    qa_d = (m2s_valid && pos_q == 4'h0) ? m2s_data : qa_q;
    qf_d = (m2s_valid && pos_q == 4'h1) ? m2s_data : qf_q;
    qn_d = (m2s_valid && pos_q == 4'h5) ? m2s_data : qn_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pos_q <= 4'h0;
      spos_q <= 8'h00;
      qa_q <= 8'h00;
      qf_q <= 8'h00;
      qn_q <= 8'h00;
    end else begin
      pos_q <= pos_d;
      spos_q <= spos_d;
      qa_q <= qa_d;
      qf_q <= qf_d;
      qn_q <= qn_d;
    end
  end

  // ----
  // Link properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence rsp_first;
    s2m_valid && spos_q == 8'h00;
  endsequence
  sequence rsp_fn(logic [7:0] f);
    rsp_first ##1 (s2m_valid && s2m_data == f);
  endsequence

  a_query_shape: assert property (m2s_valid && pos_q == 4'h0 |->
    (m2s_valid && !m2s_end)[*7] ##1 (m2s_valid && m2s_end)) else $error("query not 8 bytes");
  a_query_station: assert property (m2s_valid && pos_q == 4'h0 |->
    m2s_data <= STATION_MAX) else $error("query station out of range");
  a_read_limit: assert property (m2s_valid && pos_q == 4'h1 && m2s_data == FN_READ |->
    ##3 m2s_data == 8'h00 ##1 (m2s_data != 8'h00 && m2s_data <= 8'h7D))
    else $error("read count out of range");
  a_reply_addr: assert property (rsp_first |->
    s2m_data == qa_q && qa_q != BCAST_ADDR) else $error("reply address wrong");
  a_reply_func: assert property (rsp_first |->
    ##1 (s2m_valid && (s2m_data == qf_q || s2m_data == (qf_q | EXC_FLAG))))
    else $error("reply function wrong");
  a_echo_len: assert property (rsp_fn(FN_WRITE) or rsp_fn(FN_DIAG) |->
    ##1 (s2m_valid && !s2m_end)[*5] ##1 (s2m_valid && s2m_end)) else $error("echo length wrong");
  a_exc_len: assert property (rsp_first ##1 (s2m_valid && s2m_data[7]) |->
    ##1 (s2m_valid && !s2m_end)[*2] ##1 (s2m_valid && s2m_end)) else $error("exception length");
  a_read_bytes: assert property (rsp_fn(FN_READ) |->
    ##1 (s2m_valid && s2m_data == {qn_q[6:0], 1'b0})) else $error("byte count wrong");
  a_half_duplex: assert property (s2m_valid |-> !m2s_valid)
    else $error("query during reply");
endmodule

// >>> sim/test_rtu_slave_register_access.sv
module test_rtu_slave_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_done, rsp_crc_ok, rsp_exc;
  logic rsp_timeout, rsp_refused, rd_req, rd_ack, rd_err, wr_req, wr_ack, wr_err;
  logic frame_drop, drop_b, err_mode;
  logic [7:0] station_addr, cmd_slave, cmd_func, rsp_byte;
  logic [15:0] cmd_word_a, cmd_word_b, rd_index, rd_data, wr_index, wr_data, a, d, w;
  logic [15:0] regs [logic [15:0]];
  logic [7:0] mq[$], sq[$], got[$], sq_b[$], exp_r[$], qry[$], qb[$];
  logic [15:0] rdq[$];
  logic [31:0] wq[$];
  int err_total, compares, drops, drops_b, seed;
  int cnt[2] = '{1, 125};
  rsa_link_if link();
  rsa_link_if link_b();
  rsa_mst_end #(.BCAST_WAIT_CYC(16'h0014), .RSP_TIMEOUT_CYC(16'h0400)) rsa_mst_end_i (
    .ref_clk(ref_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_slave(cmd_slave), .cmd_func(cmd_func), .cmd_word_a(cmd_word_a),
    .cmd_word_b(cmd_word_b), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_done(rsp_done),
    .rsp_crc_ok(rsp_crc_ok), .rsp_exc(rsp_exc), .rsp_timeout(rsp_timeout),
    .rsp_refused(rsp_refused));
  rsa_dev_end rsa_dev_end_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .station_addr(station_addr), .rd_req(rd_req), .rd_index(rd_index), .rd_ack(rd_ack),
    .rd_data(rd_data), .rd_err(rd_err), .wr_req(wr_req), .wr_index(wr_index),
    .wr_data(wr_data), .wr_ack(wr_ack), .wr_err(wr_err), .frame_drop(frame_drop));
  // The second device only sees diagnostics, so its register side stays idle.
  rsa_dev_end rsa_dev_end_i2 (.ref_clk(ref_clk), .rst(rst), .link(link_b),
    .station_addr(station_addr), .rd_req(), .rd_index(), .rd_ack(1'b0),
    .rd_data(rd_data), .rd_err(rd_err), .wr_req(), .wr_index(), .wr_data(),
    .wr_ack(1'b0), .wr_err(wr_err), .frame_drop(drop_b));
  rsa_link_sva rsa_link_sva_i (.ref_clk(ref_clk), .rst(rst), .m2s_data(link.m2s_data),
    .m2s_valid(link.m2s_valid), .m2s_end(link.m2s_end), .s2m_data(link.s2m_data),
    .s2m_valid(link.s2m_valid), .s2m_end(link.s2m_end));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----
  // Monitors and register responder
  // ----
  always @(posedge ref_clk) begin
    if (link.m2s_valid) mq.push_back(link.m2s_data);
    if (link.s2m_valid) sq.push_back(link.s2m_data);
    if (rsp_valid) got.push_back(rsp_byte);
    if (link_b.s2m_valid) sq_b.push_back(link_b.s2m_data);
    if (frame_drop) drops++;
    if (drop_b) drops_b++;
    rd_ack <= rd_req;
    wr_ack <= wr_req;
    rd_err <= err_mode;
    wr_err <= err_mode;
    if (rd_req) begin
      rdq.push_back(rd_index);
      rd_data <= regs.exists(rd_index) ? regs[rd_index] : 16'h0000;
    end
    if (wr_req) wq.push_back({wr_index, wr_data});
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmpq(string what, logic [7:0] s[$], logic [7:0] e[$]);
    chk(what, s.size(), e.size());
    foreach (e[i]) chk(what, (i < s.size()) ? s[i] : 8'hxx, e[i]);
  endtask

  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  task automatic end_of_test();
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] sl, fn, input logic [15:0] wa, wb, input logic refd, tmo);
    int n;
    qry = '{sl, fn, wa[15:8], wa[7:0], wb[15:8], wb[7:0]};
    add_crc(qry);
    if (exp_r.size() != 0) add_crc(exp_r);
    mq.delete();
    sq.delete();
    got.delete();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    cmd_slave <= sl;
    cmd_func <= fn;
    cmd_word_a <= wa;
    cmd_word_b <= wb;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp_done !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      err_total++;
      end_of_test();
    end
    repeat (3) @(posedge ref_clk);
    chk("refused", rsp_refused, refd);
    chk("timeout", rsp_timeout, tmo);
    chk("crc ok", rsp_crc_ok, exp_r.size() != 0);
    chk("exc", rsp_exc, exp_r.size() > 1 && exp_r[1][7]);
    if (refd) qry.delete();
    cmpq("query", mq, qry);
    cmpq("wire reply", sq, exp_r);
    cmpq("user reply", got, exp_r);
  endtask

  task automatic send_b(input logic [7:0] q[$]);
    foreach (q[i]) begin
      link_b.m2s_data <= q[i];
      link_b.m2s_valid <= 1'b1;
      link_b.m2s_end <= (i == q.size() - 1);
      @(posedge ref_clk);
    end
    link_b.m2s_valid <= 1'b0;
    link_b.m2s_end <= 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 76475;
    rst = 1'b1;
    {cmd_valid, err_mode} = '0;
    {cmd_slave, cmd_func, cmd_word_a, cmd_word_b} = '0;
    {link_b.m2s_data, link_b.m2s_valid, link_b.m2s_end} = '0;
    station_addr = 8'h11;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    d = 16'($random(seed));
    exp_r = '{8'h11, 8'h06, 8'h00, 8'h0D, d[15:8], d[7:0]};
    run(8'h11, 8'h06, 16'h000D, d, 1'b0, 1'b0);
    chk("write", wq.pop_front(), {16'h000D, d});
    foreach (cnt[j]) begin
      a = 16'($random(seed));
      exp_r = '{8'h11, 8'h03, 8'(2 * cnt[j])};
      rdq.delete();
      for (int i = 0; i < cnt[j]; i++) begin
        w = 16'($random(seed));
        regs[a + 16'(i)] = w;
        exp_r.push_back(w[15:8]);
        exp_r.push_back(w[7:0]);
      end
      run(8'h11, 8'h03, a, 16'(cnt[j]), 1'b0, 1'b0);
      for (int i = 0; i < cnt[j]; i++) chk("rd index", rdq[i], a + 16'(i));
    end
    err_mode = 1'b1;
    exp_r = '{8'h11, 8'h83, 8'h02};
    run(8'h11, 8'h03, a, 16'h0002, 1'b0, 1'b0);
    exp_r = '{8'h11, 8'h86, 8'h02};
    run(8'h11, 8'h06, a, d, 1'b0, 1'b0);
    err_mode = 1'b0;
    exp_r = '{8'h11, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
    run(8'h11, 8'h08, 16'h0000, d, 1'b0, 1'b0);
    exp_r = '{8'h11, 8'h88, 8'h01};
    run(8'h11, 8'h08, 16'h0001, d, 1'b0, 1'b0);
    exp_r = '{8'h11, 8'hAB, 8'h01};
    run(8'h11, 8'h2B, a, d, 1'b0, 1'b0);
    wq.delete();
    exp_r.delete();
    run(8'h00, 8'h06, 16'h000D, d, 1'b0, 1'b0);
    chk("bcast write", wq.pop_front(), {16'h000D, d});
    drops = 0;
    run(8'h12, 8'h06, a, d, 1'b0, 1'b1);
    chk("drop", drops, 1);
    run(8'h00, 8'h03, a, 16'h0001, 1'b1, 1'b0);
    run(8'h00, 8'h08, 16'h0000, d, 1'b1, 1'b0);
    run(8'h11, 8'h03, a, 16'h007E, 1'b1, 1'b0);
    run(8'h11, 8'h03, a, 16'h0000, 1'b1, 1'b0);
    run(8'hF8, 8'h06, a, d, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      qb = '{8'h11, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
      add_crc(qb);
      exp_r = qb;
      if (k == 1) begin
        qb[7] = ~qb[7];
        exp_r.delete();
      end
      sq_b.delete();
      drops_b = 0;
      send_b(qb);
      cmpq("second link", sq_b, exp_r);
      chk("second drop", drops_b, k);
    end
    end_of_test();
  end
endmodule
